//--- verilog/irq_enable_defs.svh
// register offsets, bit positions and reset values for the smart card interrupt enable block
`ifndef IRQ_ENABLE_DEFS_SVH
`define IRQ_ENABLE_DEFS_SVH

`define IRQ_ENABLE_OFFSET      8'h0c
`define IRQ_STATUS_OFFSET      8'h10
`define IRQ_GATE_OFFSET        8'h14
`define IRQ_ENABLE_RESET       16'h0000
`define IRQ_STATUS_RESET       16'h0000
`define IRQ_GATE_RESET         1'b0
`define IRQ_COUNT              16
`define BIT_DEACT              15
`define BIT_ACT                14
`define BIT_INSERT             13
`define BIT_REMOVE             12
`define BIT_ATR_OK             11
`define BIT_ATR_FAIL           10
`define BIT_RX_LEVEL           9
`define BIT_CHAR_GAP           8
`define BIT_RX_PERR            7
`define BIT_TX_PERR            6
`define BIT_RX_CHAR            5
`define BIT_TX_CHAR            4
`define BIT_CLOCK              3
`define BIT_RX_FULL            2
`define BIT_TX_EMPTY           1
`define BIT_TX_DRAINED         0
`define BUS_ZERO               32'h0000_0000

`endif

//--- verilog/irq_enable_pkg.sv
// types shared by the smart card interrupt enable block
package irq_enable_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	// raw conditions from the reader datapath; pulses unless noted
	typedef struct packed {
		logic deact_done;
		logic act_done;
		logic card_inserted;
		logic card_removed;
		logic atr_ok;
		logic atr_fail;
		logic rx_at_level;      // level: fifo count >= threshold
		logic gap_limit;        // gap counter reached its limit
		logic atr_start;        // window for the gap event opens
		logic atr_restart;      // window closes
		logic rx_parity_bad;    // wrong-parity char received
		logic rx_retry_over;    // level: repeat count above rx_retry_limit
		logic proto_t1;         // level: T=1 in use
		logic tx_parity_final;  // error in guard time after tx_retry_limit repeats
		logic rx_char;
		logic tx_char;
		logic clock_halted;     // card clock stopped after halt request
		logic clock_resumed;    // card clock fully running after release
		logic rx_full;          // level
		logic tx_empty;         // level
		logic tx_drained;
	} card_events_t;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_t;

endpackage

//--- verilog/irq_rise_detect.sv
// rising-edge detector turning a level condition into a one-cycle event
`timescale 1ns/1ns
module irq_rise_detect
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// condition
	input  wire logic level,
	output logic      rise
);
	logic last;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			last <= 1'b0;
		else if (ce)
			last <= level;
	end

	assign rise = level & ~last & ce;
endmodule

//--- verilog/smart_card_irq_enable.sv
// smart card reader interrupt enable and status registers on a classic wishbone slave
// How it works
// - sixteen-bit enable register at 0x0c, read-write, all zero after reset.
// - enable bit 15 passes the deactivation-complete event.
// - enable bit 14 passes the activation-complete event.
// - enable bit 13 passes the card-inserted event.
// - enable bit 12 passes the card-removed event.
// - enable bit 11 passes the answer-to-reset success event.
// - enable bit 10 passes the answer-to-reset failure event.
// - enable bit 9 passes receive fifo count reaching threshold.
// - enable bit 8 passes the character gap limit event.
// - gap event counted only between ATR start and deactivation or restart.
// - bit 7: wrong parity received with retries exceeded or T=1.
// - bit 6: card flags parity after all transmit repeats used.
// - enable bit 5 passes each received character.
// - enable bit 4 passes each transmitted character.
// - bit 3 raised when card clock has halted after request.
// - bit 3 also raised when card clock fully runs again.
// - enable bit 2 passes receive fifo becoming full.
// - enable bit 1 passes transmit fifo becoming empty.
// - enable bit 0 passes transmit fifo fully delivered.
// - status register at 0x10 holds events at the same bit positions.
`timescale 1ns/1ns
`include "irq_enable_defs.svh"
module smart_card_irq_enable
(
	// clock, reset, enable
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	// wishbone slave
	input  wire irq_enable_pkg::wb_req_t  wb_req,
	output irq_enable_pkg::wb_rsp_t       wb_rsp,
	// reader datapath
	input  wire irq_enable_pkg::card_events_t events,
	// interrupt
	output logic                          irq
);
	import irq_enable_pkg::*;

	logic                     rst_meta;
	logic                     rst_sync_n;
	logic [15:0]              enable;
	logic [15:0]              status;
	logic                     gap_window;
	logic                     gate;
	logic [15:0]              raw;
	logic [15:0]              next_status;
	logic [15:0]              wr_mask;
	logic [15:0]              wr_data;
	logic                     sel_enable;
	logic                     sel_status;
	logic                     sel_gate;
	logic                     access;
	logic                     rx_level_rise;
	logic                     rx_full_rise;
	logic                     tx_empty_rise;
	bus_state_t               bus_state;
	logic                     ack;
	logic [31:0]              rd_data;
	logic [31:0]              next_rd;

	// reset released through two flops; the rest uses the synchronised copy
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// level conditions only count on their rising edge so a lasting level
	// does not refill a status bit the moment software clears it
	irq_rise_detect u_rx_level
	(
		.clk   (core_clk),
		.rst_n (rst_sync_n),
		.ce    (clk_en),
		.level (events.rx_at_level),
		.rise  (rx_level_rise)
	);

	irq_rise_detect u_rx_full
	(
		.clk   (core_clk),
		.rst_n (rst_sync_n),
		.ce    (clk_en),
		.level (events.rx_full),
		.rise  (rx_full_rise)
	);

	irq_rise_detect u_tx_empty
	(
		.clk   (core_clk),
		.rst_n (rst_sync_n),
		.ce    (clk_en),
		.level (events.tx_empty),
		.rise  (tx_empty_rise)
	);

	// bus decode
	assign access     = wb_req.cyc & wb_req.stb & (bus_state == BUS_IDLE) & clk_en;
	assign sel_enable = (wb_req.adr == `IRQ_ENABLE_OFFSET);
	assign sel_status = (wb_req.adr == `IRQ_STATUS_OFFSET);
	assign sel_gate   = (wb_req.adr == `IRQ_GATE_OFFSET);
	assign wr_mask    = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
	assign wr_data    = wb_req.dat[15:0];

	// window in which the gap event may count
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			gap_window <= 1'b0;
		else if (clk_en)
		begin
			if (events.deact_done | events.atr_restart)
				gap_window <= 1'b0;
			else if (events.atr_start)
				gap_window <= 1'b1;
		end
	end

	// raw event vector at the status bit positions
	always_comb
	begin
		raw                   = 16'h0000;
		raw[`BIT_DEACT]       = events.deact_done;
		raw[`BIT_ACT]         = events.act_done;
		raw[`BIT_INSERT]      = events.card_inserted;
		raw[`BIT_REMOVE]      = events.card_removed;
		raw[`BIT_ATR_OK]      = events.atr_ok;
		raw[`BIT_ATR_FAIL]    = events.atr_fail;
		raw[`BIT_RX_LEVEL]    = rx_level_rise;
		raw[`BIT_CHAR_GAP]    = events.gap_limit & gap_window;
		raw[`BIT_RX_PERR]     = events.rx_parity_bad
			& (events.rx_retry_over | events.proto_t1);
		raw[`BIT_TX_PERR]     = events.tx_parity_final;
		raw[`BIT_RX_CHAR]     = events.rx_char;
		raw[`BIT_TX_CHAR]     = events.tx_char;
		raw[`BIT_CLOCK]       = events.clock_halted
			| events.clock_resumed;
		raw[`BIT_RX_FULL]     = rx_full_rise;
		raw[`BIT_TX_EMPTY]    = tx_empty_rise;
		raw[`BIT_TX_DRAINED]  = events.tx_drained;
	end

	// status: write one to clear, a new event in the same cycle wins
	always_comb
	begin
		next_status = status;
		if (access & wb_req.we & sel_status)
			next_status = status & ~(wr_data & wr_mask);
		next_status = next_status | raw;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			status <= `IRQ_STATUS_RESET;
		else if (clk_en)
			status <= next_status;
	end

	// enable register
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			enable <= `IRQ_ENABLE_RESET;
		else if (access & wb_req.we & sel_enable)
			enable <= (enable & ~wr_mask) | (wr_data & wr_mask);
	end

	// global output gate, bit 0 of the gate register
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			gate <= `IRQ_GATE_RESET;
		else if (access & wb_req.we & sel_gate & wb_req.sel[0])
			gate <= wb_req.dat[0];
	end

	// combinational so a cleared enable masks in the same cycle
	assign irq = gate & (|(status & enable));

	// read data
	always_comb
	begin
		next_rd = `BUS_ZERO;
		if (sel_enable)
			next_rd[15:0] = enable;
		else if (sel_status)
			next_rd[15:0] = status;
		else if (sel_gate)
			next_rd[0] = gate;
	end

	// one-wait-state slave: ack one cycle after the request, then drop
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			bus_state <= BUS_IDLE;
			ack       <= 1'b0;
			rd_data   <= `BUS_ZERO;
		end
		else if (clk_en)
		begin
			unique case (bus_state)
				BUS_IDLE:
				begin
					if (access)
					begin
						bus_state <= BUS_ACK;
						ack       <= 1'b1;
						rd_data   <= wb_req.we ? `BUS_ZERO : next_rd;
					end
				end
				BUS_ACK:
				begin
					bus_state <= BUS_IDLE;
					ack       <= 1'b0;
				end
			endcase
		end
	end

	assign wb_rsp.ack = ack;
	assign wb_rsp.dat = rd_data;
endmodule

//--- tb/irq_enable_asserts.sv
// port-level checks for the smart card interrupt enable block
`timescale 1ns/1ns
module irq_enable_asserts
(
	// clock and reset
	input wire logic                         core_clk,
	input wire logic                         rst_n,
	input wire logic                         clk_en,
	// bus, events, interrupt
	input wire irq_enable_pkg::wb_req_t      wb_req,
	input wire irq_enable_pkg::wb_rsp_t      wb_rsp,
	input wire irq_enable_pkg::card_events_t events,
	input wire logic                         irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_rsp.ack |-> $past(wb_req.stb) && $past(clk_en))
		else $error("ack without request");
	AST_ACK_BOUND: assert property ($rose(wb_req.stb) |-> ##[1:20] wb_rsp.ack) else $error("no ack");
	AST_IDLE_FROZEN: assert property (!clk_en && !wb_rsp.ack |=> !wb_rsp.ack) else $error("ack frozen");
	AST_WACK_ZERO: assert property (wb_rsp.ack && $past(wb_req.we) |-> wb_rsp.dat == 32'h0)
		else $error("write ack data");
	AST_UPPER_ZERO: assert property (wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0) else $error("upper bits");
	AST_RST_QUIET: assert property ($rose(rst_n) |-> !irq [*3]) else $error("irq after reset");
	// a level event passes the edge detector in the same cycle, with no flop delay; the second past sample is only slack
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(events) != '0 || $past(events, 2) != '0
		|| $past(wb_req.we)) else $error("irq rose without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wb_req.we) && $past(wb_req.stb))
		else $error("irq fell without write");
	cover property (wb_rsp.ack && !$past(wb_req.we));
	cover property ($rose(irq));
	cover property ($fell(irq));
endmodule
bind smart_card_irq_enable irq_enable_asserts chk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
	.wb_req(wb_req), .wb_rsp(wb_rsp), .events(events), .irq(irq));

//--- tb/card_path_model.sv
// reader datapath stand-in: one event line per request, protocol levels held
`timescale 1ns/1ns
module card_path_model
(
	// clock
	input  wire logic                    core_clk,
	// bench control
	input  wire logic                    fire,
	input  wire logic [4:0]              sel,
	input  wire logic [1:0]              mode,
	// to the block
	output irq_enable_pkg::card_events_t events
);
	import irq_enable_pkg::*;
	logic [20:0] pulse;
	// one cycle per event, as the sequencers report completions
	always_ff @(posedge core_clk)
	begin
		pulse <= fire ? 21'h1 << sel : 21'h0;
	end
	assign events = card_events_t'(pulse | {11'h0, mode, 8'h0});
endmodule

//--- tb/testbench.sv
// self-checking bench for the smart card interrupt enable block
`timescale 1ns/1ns
module testbench;
	import irq_enable_pkg::*;
	logic         core_clk;
	logic         rst_n;
	logic         clk_en;
	logic         fire;
	logic [4:0]   sel;
	logic [1:0]   mode;
	logic [31:0]  seed;
	logic [31:0]  q;
	logic [15:0]  en;
	logic [15:0]  e;
	wb_req_t      req;
	wb_rsp_t      rsp;
	card_events_t ev;
	logic         irq;
	int           n_errors;
	int           samples_checked;
	int           ticks;
	// status bit fed by each event line; -1 where the line only qualifies others
	localparam int bit_of [0:20] = '{0, 1, 2, 3, 3, 4, 5, 6, -1, -1, 7, -1, -1, 8, 9, 10, 11, 12, 13, 14, 15};

	smart_card_irq_enable DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .wb_req(req),
		.wb_rsp(rsp), .events(ev), .irq(irq));
	card_path_model peer (.core_clk(core_clk), .fire(fire), .sel(sel), .mode(mode), .events(ev));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] exp_st(input int i, input logic [1:0] m);
		if (bit_of[i] < 0 || (i == 10 && m == 2'h0))
			return 16'h0;
		return 16'h1 << bit_of[i];
	endfunction

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// waits for ack with no cycle budget of its own; only the bench watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge core_clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
		do
		begin
			@(posedge core_clk);
		end
		while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req <= '0;
	endtask

	task automatic pulse(input int i);
		@(posedge core_clk);
		sel <= 5'(i);
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			n_errors++;
			finish_test;
		end
	end

	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b0;
		fire = 1'b0;
		sel = 5'h00;
		mode = 2'h0;
		req = '0;
		seed = 32'h87b5cde3;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		clk_en <= 1'b1;
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		check("enable reset", q, 32'h0);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		check("status reset", q, 32'h0);
		bus(1'b1, 8'h0c, 32'hffff, 4'hf);
		seed = lfsr(seed);
		en = {8'hff, seed[7:0]};
		// high lane not selected, so its ones must survive
		bus(1'b1, 8'h0c, seed, 4'h1);
		bus(1'b0, 8'h0c, 32'h0, 4'hf);
		check("enable rw", q, {16'h0, en});
		bus(1'b0, 8'h3c, 32'h0, 4'hf);
		check("unmapped", q, 32'h0);
		bus(1'b1, 8'h14, 32'h1, 4'hf);
		for (int p = 0; p < 2; p++)
		begin
			seed = lfsr(seed);
			mode <= p ? {seed[0], ~seed[0]} : 2'h0;
			for (int i = 0; i < 21; i++)
			begin
				pulse(i);
				e = exp_st(i, mode);
				bus(1'b0, 8'h10, 32'h0, 4'hf);
				check("status", q, {16'h0, e});
				check("irq", {31'h0, irq}, {31'h0, |(e & en)});
				bus(1'b1, 8'h10, 32'hffff, 4'hf);
			end
		end
		// deactivation closed the window, then a restart closes it again
		pulse(13);
		pulse(12);
		pulse(11);
		pulse(13);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		check("gap closed", q, 32'h0);
		pulse(20);
		check("irq on", {31'h0, irq}, 32'h1);
		bus(1'b1, 8'h0c, 32'h0, 4'hf);
		check("irq masked", {31'h0, irq}, 32'h0);
		bus(1'b0, 8'h10, 32'h0, 4'hf);
		check("status kept", q, 32'h8000);
		finish_test;
	end
endmodule
